// [logic/pyro_readout.sv]
// detector-side single-wire serial readout of sensor and temperature samples
`timescale 1ns/1ps
module pyro_readout #(
  parameter int UPDATE_CYCLES = pyro_link_pkg::SAMPLE_UPDATE_CYCLES,
  parameter int OSC_DIV       = pyro_link_pkg::OSC_CYCLES,
  parameter int SETTLE_CYCLES = pyro_link_pkg::BIT_SETTLE_CYCLES
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 link_clk,
  input  wire logic                                 line_in,
  output logic                                      line_out,
  output logic                                      line_oe,
  input  wire logic [pyro_link_pkg::FIELD_BITS-1:0] sensor_value,
  input  wire logic [pyro_link_pkg::FIELD_BITS-1:0] temp_value,
  output logic                                      short_input,
  output logic                                      frame_active
);
  import pyro_link_pkg::*;

  // ***********************************************
  // elaboration checks
  // ***********************************************
  localparam int UPD_W = $clog2(UPDATE_CYCLES + 1);
  localparam int OSC_W = $clog2(OSC_DIV + 1);
  localparam int SET_W = $clog2(SETTLE_CYCLES + 1);

  if (UPDATE_CYCLES < 64) begin : g_upd_chk
    $error("update period too short to hold a frame");
  end
  if (OSC_DIV < 2) begin : g_osc_chk
    $error("oscillator divider must be at least two");
  end
  // the settle counter also times the start guard, so it must reach that count
  localparam int START_GUARD = 8;
  if (SETTLE_CYCLES < START_GUARD) begin : g_set_chk
    $error("settle count must cover the start guard");
  end

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [EDGE_W-1:0] gray_to_bin(input logic [EDGE_W-1:0] g);
    logic [EDGE_W-1:0] b;
    b = g;
    for (int i = EDGE_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic out_of_range(input logic [FIELD_BITS-1:0] v);
    return (v > RANGE_HIGH) || (v < RANGE_LOW);
  endfunction

  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    link_state_type        state;
    logic [EDGE_W-1:0]     gray_s1;
    logic [EDGE_W-1:0]     gray_s2;
    logic [EDGE_W-1:0]     base;
    logic                  line_s1;
    logic                  line_s2;
    logic [UPD_W-1:0]      upd_cnt;
    logic [UPD_W-1:0]      since_read;
    logic [OSC_W-1:0]      osc_cnt;
    logic [9:0]            short_cnt;
    logic [FRAME_BITS-1:0] word;
    logic                  zero;
    logic [SET_W-1:0]      settle_cnt;
    logic                  line_out;
    logic                  line_oe;
    logic                  short_on;
    logic                  active;
  } core_type;

  core_type          st_ff;
  core_type          nxt_st;
  logic [EDGE_W-1:0] edges;
  logic              upd_tick;
  logic              osc_tick;
  logic [4:0]        bit_idx;

  edge_link_if link_if ();

  host_edge_counter u_edges (
    .link_clk (link_clk),
    .reset_n  (reset_n),
    .link     (link_if.counter)
  );

  // host edges seen since the start of this frame
  assign edges    = gray_to_bin(st_ff.gray_s2) - st_ff.base;
  assign upd_tick = (st_ff.upd_cnt == UPD_W'(UPDATE_CYCLES - 1));
  assign osc_tick = (st_ff.osc_cnt == OSC_W'(OSC_DIV - 1));
  // edge 1 selects bit 27, edge 28 selects bit 0
  assign bit_idx  = (edges >= 8'd1 && edges <= 8'd28) ? 5'(FRAME_BITS - int'(edges)) : 5'h00;

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.gray_s1 = link_if.edge_gray;
    nxt_st.gray_s2 = st_ff.gray_s1;
    nxt_st.line_s1 = line_in;
    nxt_st.line_s2 = st_ff.line_s1;

    nxt_st.upd_cnt = upd_tick ? '0 : st_ff.upd_cnt + UPD_W'(1);
    nxt_st.osc_cnt = osc_tick ? '0 : st_ff.osc_cnt + OSC_W'(1);
    if (st_ff.since_read != '1) begin
      nxt_st.since_read = st_ff.since_read + UPD_W'(1);
    end

    // input short runs on the internal oscillator, not on the link
    if (osc_tick && st_ff.short_cnt != 10'h000) begin
      nxt_st.short_cnt = st_ff.short_cnt - 10'h001;
    end

    case (st_ff.state)
      IDLE_LOW: begin
        nxt_st.line_oe  = 1'b1;
        nxt_st.line_out = 1'b0;
        nxt_st.active   = 1'b0;
        if (upd_tick) begin
          nxt_st.word     = {sensor_value, temp_value};
          nxt_st.base     = gray_to_bin(st_ff.gray_s2);
          nxt_st.settle_cnt = '0;
          nxt_st.state    = START_HIGH;
          nxt_st.line_out = 1'b1;
          nxt_st.active   = 1'b1;
          if (out_of_range(sensor_value) && st_ff.short_cnt == 10'h000) begin
            nxt_st.short_cnt = SHORT_OSC_CYCLES;
          end
        end
      end
      START_HIGH: begin
        nxt_st.line_out = 1'b1;
        // the line is held high by us here, so no refresh is taken
        // our own start edge also clocks the edge counter; absorb it while the
        // host is still bound to its long setup wait
        if (st_ff.settle_cnt != SET_W'(START_GUARD)) begin
          nxt_st.settle_cnt = st_ff.settle_cnt + SET_W'(1);
          nxt_st.base       = gray_to_bin(st_ff.gray_s2);
        end else if (edges != 8'h00) begin
          nxt_st.zero       = (st_ff.since_read < UPD_W'(UPDATE_CYCLES));
          nxt_st.since_read = '0;
          nxt_st.state      = SHIFT_BITS;
        end
      end
      SHIFT_BITS: begin
        // device drives each frame bit, or a zero after a too early read, on the shared line between host pulses
        nxt_st.line_out = st_ff.zero ? 1'b0 : st_ff.word[bit_idx];
        if (upd_tick && !st_ff.line_s2) begin
          // a long low pause lets a new sample in; the old frame is lost
          nxt_st.word = {sensor_value, temp_value};
          if (out_of_range(sensor_value) && st_ff.short_cnt == 10'h000) begin
            nxt_st.short_cnt = SHORT_OSC_CYCLES;
          end
        end
        if (edges >= 8'd28) begin
          nxt_st.settle_cnt = '0;
          nxt_st.state      = LAST_SETTLE;
        end
      end
      LAST_SETTLE: begin
        // hold bit zero for the settle time and until the host forces the line low;
        // a slow host would otherwise read a low level instead of bit zero
        if (st_ff.settle_cnt != SET_W'(SETTLE_CYCLES)) begin
          nxt_st.settle_cnt = st_ff.settle_cnt + SET_W'(1);
        end else if (!st_ff.line_s2) begin
          nxt_st.state    = IDLE_LOW;
          nxt_st.line_out = 1'b0;
          nxt_st.active   = 1'b0;
        end
      end
      default: begin
        nxt_st.state    = IDLE_LOW;
        nxt_st.line_out = 1'b0;
        nxt_st.line_oe  = 1'b1;
      end
    endcase

    nxt_st.short_on = (nxt_st.short_cnt != 10'h000);
  end

  // ***********************************************
  // registers
  // ***********************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '{state: IDLE_LOW, since_read: '1, line_oe: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign line_out     = st_ff.line_out;
  assign line_oe      = st_ff.line_oe;
  assign short_input  = st_ff.short_on;
  assign frame_active = st_ff.active;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  logic [11:0] osc_gap_ff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_gap_ff <= 12'h000;
    end else if (osc_tick) begin
      osc_gap_ff <= 12'h000;
    end else begin
      osc_gap_ff <= osc_gap_ff + 12'h001;
    end
  end

  sequence s_sample_ready;
    st_ff.state == IDLE_LOW && upd_tick;
  endsequence

  sequence s_start_driven;
    st_ff.state == START_HIGH && line_oe && line_out;
  endsequence

  sequence s_last_edge;
    st_ff.state == SHIFT_BITS && edges == 8'd28;
  endsequence

  sequence s_start_settled;
    st_ff.state == START_HIGH && st_ff.settle_cnt == SET_W'(START_GUARD);
  endsequence

  sequence s_host_forced;
    st_ff.state == LAST_SETTLE && st_ff.settle_cnt == SET_W'(SETTLE_CYCLES) && !st_ff.line_s2;
  endsequence

  start_high_a: assert property (s_sample_ready |=> s_start_driven)
    else $error("start not driven high after a fresh sample");

  idle_low_a: assert property (st_ff.state == IDLE_LOW |-> line_oe && !line_out)
    else $error("line not held low between transfers");

  frame_end_a: assert property (s_last_edge |=> st_ff.state == LAST_SETTLE ##1
                                (st_ff.state == LAST_SETTLE)[*8])
    else $error("frame did not end after 28 edges");

  msb_first_a: assert property (st_ff.state == SHIFT_BITS && !st_ff.zero && edges == 8'd1
                                |=> line_out == $past(st_ff.word[FRAME_BITS-1]))
    else $error("first bit is not the most significant");

  sensor_first_a: assert property (s_sample_ready |=> st_ff.word[FRAME_BITS-1:FIELD_BITS]
                                   == $past(sensor_value))
    else $error("sensor field not in upper half of frame");

  fast_read_zero_a: assert property (st_ff.state == SHIFT_BITS && st_ff.zero
                                     |=> !line_out)
    else $error("too early read returned non-zero bit");

  low_refresh_a: assert property (st_ff.state == SHIFT_BITS && upd_tick && !st_ff.line_s2
                                  |=> st_ff.word == $past({sensor_value, temp_value}))
    else $error("long low pause did not reload sample");

  high_hold_a: assert property (st_ff.state == SHIFT_BITS && st_ff.line_s2
                                |=> $stable(st_ff.word))
    else $error("frame refreshed while line held high");

  update_period_a: assert property (upd_tick |=> !upd_tick [*8])
    else $error("update ticks too close together");

  osc_rate_a: assert property (osc_tick |-> osc_gap_ff == 12'(OSC_DIV - 1))
    else $error("oscillator tick spacing wrong");

  short_start_a: assert property ($rose(short_input) |-> short_input [*8])
    else $error("input short too brief");

  short_len_a: assert property (st_ff.short_cnt == SHORT_OSC_CYCLES && osc_tick
                                |=> st_ff.short_cnt == SHORT_OSC_CYCLES - 10'h001)
    else $error("input short counter not stepping on oscillator");

  start_guard_a: assert property (st_ff.state == START_HIGH && st_ff.settle_cnt != SET_W'(START_GUARD)
                                  |=> st_ff.state == START_HIGH)
    else $error("own start edge taken as a host edge");

  start_word_a: assert property (st_ff.state == START_HIGH |=> $stable(st_ff.word))
    else $error("frame changed while start indicated");

  last_bit_hold_a: assert property (st_ff.state == LAST_SETTLE && st_ff.line_s2
                                    |=> st_ff.state == LAST_SETTLE && $stable(line_out))
    else $error("last bit dropped before host forced low");

  forced_low_a: assert property (s_host_forced |=> st_ff.state == IDLE_LOW && !line_out && !frame_active)
    else $error("line not back low after host forced it");

  bit_follows_a: assert property (st_ff.state == SHIFT_BITS && !st_ff.zero && edges >= 8'd1 && edges <= 8'd28
                                  |=> line_out == $past(st_ff.word[bit_idx]))
    else $error("driven bit does not follow host edge count");

  active_span_a: assert property (frame_active |-> st_ff.state != IDLE_LOW)
    else $error("frame flag high while idle");

  temp_second_a: assert property (s_sample_ready |=> st_ff.word[FIELD_BITS-1:0] == $past(temp_value))
    else $error("temperature field not in lower half of frame");

  zero_flag_a: assert property (s_start_settled ##0 (edges != 8'h00 && st_ff.since_read < UPD_W'(UPDATE_CYCLES))
                                |=> st_ff.zero)
    else $error("early read not marked for zero data");

endmodule // pyro_readout

// [logic/pyro_link_pkg.sv]
// shared constants for the single-wire detector readout
package pyro_link_pkg;

  localparam real    REF_CLK_HZ                = 40.0e6;
  localparam int     REF_CLK_PERIOD_NS         = 25;
  localparam real    SAMPLE_UPDATE_PERIOD_MS   = 14.6;
  localparam int     SAMPLE_UPDATE_CYCLES      = $rtoi(SAMPLE_UPDATE_PERIOD_MS * 1.0e-3 * REF_CLK_HZ);
  localparam int     BIT_SETTLE_TIME_NS        = 1000;
  localparam int     BIT_SETTLE_CYCLES         = (BIT_SETTLE_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam real    INTERNAL_OSC_FREQUENCY_KHZ = 35.0;
  localparam int     OSC_CYCLES                = $rtoi(REF_CLK_HZ / (INTERNAL_OSC_FREQUENCY_KHZ * 1.0e3));

  localparam int     FIELD_BITS                = 14;
  localparam int     FRAME_BITS                = 28;
  localparam int     EDGE_W                    = 8;
  localparam logic [13:0] RANGE_HIGH           = 14'h3E00;
  localparam logic [13:0] RANGE_LOW            = 14'h01FF;
  localparam logic [9:0]  SHORT_OSC_CYCLES     = 10'h200;

  typedef enum logic [1:0] {
    IDLE_LOW,
    START_HIGH,
    SHIFT_BITS,
    LAST_SETTLE
  } link_state_type;

endpackage

// [logic/edge_link_if.sv]
// carries the gray-coded host edge count from the link domain to the core
`timescale 1ns/1ps
interface edge_link_if;
  logic [pyro_link_pkg::EDGE_W-1:0] edge_gray;
  modport counter (output edge_gray);
  modport core    (input  edge_gray);
endinterface

// [logic/host_edge_counter.sv]
// counts rising edges of the shared line in its own clock domain
`timescale 1ns/1ps
module host_edge_counter (
  input wire logic           link_clk,
  input wire logic           reset_n,
  edge_link_if.counter       link
);
  import pyro_link_pkg::*;

  logic [EDGE_W-1:0] count_ff;
  logic [EDGE_W-1:0] gray_ff;
  logic [EDGE_W-1:0] nxt_count;

  // the line clock stands still between frames, so only a free count lives here
  assign nxt_count = count_ff + 8'h01;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= 8'h00;
      gray_ff  <= 8'h00;
    end else begin
      count_ff <= nxt_count;
      // gray code so the core may sample it while it moves
      gray_ff  <= nxt_count ^ (nxt_count >> 1);
    end
  end

  assign link.edge_gray = gray_ff;

endmodule // host_edge_counter

// [verification/host_link_model.sv]
// host-side model of the single-wire readout: clocks the detector and collects each frame
`timescale 1ns/1ps
module host_link_model (
  input  wire logic        line,
  input  wire logic [31:0] setup_ns,
  input  wire logic [31:0] pause_ns,
  output logic             host_oe,
  output logic             host_drv,
  output logic [27:0]      word,
  output logic             done
);
  // ******************
  // frame sequencer
  // ******************
  // 240 ns phases are five periods of the 48 ns link clock, safely above the 200 ns floor
  localparam int PHASE_NS  = 240;
  // settle kept above the 1 us minimum to leave margin on the low level
  localparam int SETTLE_NS = 1200;
  initial begin
    host_oe  = 1'b0;
    host_drv = 1'b0;
    word     = '0;
    done     = 1'b0;
    forever begin
      @(posedge line);
      #(setup_ns);
      for (int i = 27; i >= 0; i--) begin
        host_drv = 1'b0;
        host_oe  = 1'b1;
        #(PHASE_NS);
        host_drv = 1'b1;
        #(PHASE_NS);
        // a long pause is only safe with the line held high
        if (i == 14) #(pause_ns);
        host_oe = 1'b0;
        #(SETTLE_NS);
        word[i] = line;
      end
      host_drv = 1'b0;
      host_oe  = 1'b1;
      #(PHASE_NS);
      host_oe = 1'b0;
      done    = 1'b1;
      #(PHASE_NS);
      done    = 1'b0;
    end
  end
endmodule // host_link_model

// [verification/tb.sv]
// self-checking bench for the detector-side single-wire readout
`timescale 1ns/1ps
module tb;
  import pyro_link_pkg::*;
  // ******************
  // signals
  // ******************
  localparam int OSC = 4;
  logic                  ref_clk;
  logic                  reset_n;
  logic                  line;
  logic                  line_out;
  logic                  line_oe;
  logic [FIELD_BITS-1:0] sensor_value;
  logic [FIELD_BITS-1:0] temp_value;
  logic                  short_input;
  logic                  frame_active;
  logic                  host_oe;
  logic                  host_drv;
  logic [FRAME_BITS-1:0] host_word;
  logic                  host_done;
  logic [31:0]           setup_ns;
  logic [31:0]           pause_ns;
  logic [FRAME_BITS-1:0] frame_q[$];
  logic                  short_q[$];
  int                    err_total;
  int                    tests_run;
  int                    seed;
  logic [13:0]           sens_tab[8] = '{14'h0000, 14'h3E01, 14'h2000, 14'h01FE, 14'h3E00, 14'h01FF, 14'h3FFF, 14'h0000};
  // first host edges stay clear of exactly one update period, except frame 2
  int                    setup_tab[8] = '{25000, 40000, 25000, 30000, 25000, 30000, 35000, 40000};

  always #12.5 ref_clk = ~ref_clk;
  // host drive wins over the device; the pad pull-down holds an undriven line low
  assign line = host_oe ? host_drv : (line_oe ? line_out : 1'b0);

  // update period shortened to 100 us so a fast second read lands inside it
  pyro_readout #(.UPDATE_CYCLES(4000), .OSC_DIV(OSC), .SETTLE_CYCLES(40)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .link_clk(line), .line_in(line),
    .line_out(line_out), .line_oe(line_oe), .sensor_value(sensor_value),
    .temp_value(temp_value), .short_input(short_input), .frame_active(frame_active));

  host_link_model host (
    .line(line), .setup_ns(setup_ns), .pause_ns(pause_ns), .host_oe(host_oe),
    .host_drv(host_drv), .word(host_word), .done(host_done));

  // ******************
  // compare and verdict
  // ******************
  task automatic chk_word(input logic [FRAME_BITS-1:0] got, input logic [FRAME_BITS-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ******************
  // observers
  // ******************
  always @(posedge host_done) begin
    chk_word(host_word, frame_q.pop_front());
  end

  always @(posedge frame_active) begin : short_watch
    logic s;
    int   n;
    repeat (3) @(posedge ref_clk);
    s = short_q.pop_front();
    chk_bit(short_input, s);
    n = 0;
    while (short_input === 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    if (s) chk_bit(n >= 510 * OSC && n <= 513 * OSC, 1'b1);
  end

  // ******************
  // stimulus
  // ******************
  initial begin
    ref_clk      = 1'b0;
    reset_n      = 1'b0;
    sensor_value = '0;
    temp_value   = '0;
    setup_ns     = 32'd25000;
    pause_ns     = '0;
    err_total    = 0;
    tests_run    = 0;
    seed         = 32'h6CC39A68;
    repeat (12) @(posedge ref_clk);
    #2 reset_n = 1'b1;
    for (int f = 0; f < 8; f++) begin
      @(posedge ref_clk);
      #2;
      sensor_value = (f == 0) ? 14'(14'h0200 + $unsigned($random(seed)) % 15360) : sens_tab[f];
      temp_value   = 14'($random(seed));
      setup_ns     = setup_tab[f];
      // frame 3 parks high across a whole update period mid-frame
      pause_ns     = (f == 3) ? 32'd110000 : 32'd0;
      @(posedge frame_active);
      // frame 2 starts 85 us after the slow frame 1, inside the update period
      frame_q.push_back((f == 2) ? '0 : {sensor_value, temp_value});
      short_q.push_back(sensor_value > RANGE_HIGH || sensor_value < RANGE_LOW);
      @(negedge frame_active);
    end
    @(posedge host_done);
    #100;
    results();
  end

  initial begin
    #2000000;
    err_total++;
    results();
  end
endmodule // tb
